// File: hdl/psp_pkg.sv
// Register map, field positions and reset values of the host byte port
package host_port_pkg;
   // Register indices; the byte address on the bus is four times the index
   localparam logic [7:0] IDX_DATA = 8'h08;
   localparam logic [7:0] IDX_CPORT = 8'h09;
   localparam logic [7:0] IDX_FLAGS = 8'h0c;
   localparam logic [7:0] IDX_DDIR = 8'h88;
   localparam logic [7:0] IDX_CTRL = 8'h89;
   localparam logic [7:0] IDX_EN = 8'h8c;
   localparam logic [7:0] IDX_ANA = 8'h9f;
   localparam int ADR_LSB = 2;
   localparam int ADR_MSB = 9;
   // Control/status register fields
   localparam int IN_FULL_BIT = 7;
   localparam int OUT_FULL_BIT = 6;
   localparam int OVF_BIT = 5;
   localparam int MODE_BIT = 4;
   localparam int DIR_MSB = 2;
   // Slave port flag in the flag and enable registers
   localparam int PIF_BIT = 7;
   // Control pin roles in slave mode
   localparam int RD_PIN = 0;
   localparam int WR_PIN = 1;
   localparam int CS_PIN = 2;
   // Reset values
   localparam logic [7:0] CTRL_RST = 8'h07;
   localparam logic [7:0] DDIR_RST = 8'hff;
   localparam logic [7:0] FLAGS_RST = 8'h00;
   localparam logic [7:0] EN_RST = 8'h00;
   localparam logic [7:0] ANA_RST = 8'h00;
   // Four-phase instruction clock
   localparam logic [1:0] PHASE_TWO = 2'h1;
   localparam logic [1:0] PHASE_FOUR = 2'h3;
   localparam logic [1:0] PH_STEP = 2'h1;
endpackage

// File: hdl/host_byte_port.sv
// Parallel slave byte port with Wishbone register access
// Summary of operation
// - Mode bit 4 of control register turns data port into host slave port
// - In slave mode control pins 0,1,2 are read, write, chip select, low
// - Output latch and input latch share one address; write out, read in (in slave mode)
// - Slave mode ignores data direction register; host strobes steer pins
// - Chip select and write low: capture data pins into input latch
// - Write end sets input full and irq flag, phase four after phase two
// - Input full clears by a CPU read of the input latch or by leaving slave mode
// - Host write while input full sets overflow; software clears it
// - Chip select and read low: clear output full, drive output latch
// - Output latch stays on data pins while selected read lasts
// - Read end sets irq flag on phase four after the next phase two
// - Output full stays clear until firmware writes the output latch
// - Outside slave mode both full flags held clear; overflow kept
// - Irq flag bit 7 sticky until software clears; enable gates interrupt
// - Chip select high: no capture and no drive for any strobe
// - Control register low three bits set control pin direction, 1 input
// - Full bits read-only, overflow and mode read/write, bit 3 reads zero
`timescale 1ns/1ns
module host_byte_port
   import host_port_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [ADR_MSB:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Data pins
   input wire logic [7:0] data_i,
   output logic [7:0] data_o,
   output logic [7:0] data_oe_o,
   // Control pins
   input wire logic [2:0] ctrl_i,
   output logic [2:0] ctrl_o,
   output logic [2:0] ctrl_oe_o,
   // Interrupt
   output logic irq_o
);

   typedef struct packed {
      logic [2:0] c_m;
      logic [2:0] c_s;
      logic [7:0] d_m;
      logic [7:0] d_s;
      logic [1:0] ph;
      logic wr_act;
      logic rd_act;
      logic wr_pend;
      logic wr_arm;
      logic rd_pend;
      logic rd_arm;
      logic [7:0] out_lat;
      logic [7:0] in_lat;
      logic [7:0] ddir;
      logic [2:0] cport;
      logic [7:0] ana;
      logic [7:0] flags;
      logic [7:0] en;
      logic in_full;
      logic out_full;
      logic in_ovf;
      logic mode;
      logic [2:0] cdir;
      logic ack;
      logic [31:0] rdat;
      logic [7:0] dout;
      logic [7:0] doe;
      logic [2:0] coe;
      logic irq;
   } state_t;

   state_t st_q;
   state_t st_d;
   logic req;
   logic wr_now;
   logic rd_now;
   logic wr_start;
   logic rd_start;
   logic wr_end;
   logic rd_end;
   logic wr_fire;
   logic rd_fire;
   logic [7:0] rbyte;
   logic [ADR_MSB-ADR_LSB:0] idx;

   function automatic logic hit(input logic [ADR_MSB-ADR_LSB:0] a,
                                input logic [7:0] r);
      hit = (a == r);
   endfunction

   always_comb
   begin
      st_d = st_q;
      idx = wb_adr_i[ADR_MSB:ADR_LSB];
      req = wb_cyc_i & wb_stb_i & ~st_q.ack;
      // Strobes are seen only through the second synchroniser stage
      wr_now = st_q.mode & ~st_q.c_s[CS_PIN] & ~st_q.c_s[WR_PIN];
      rd_now = st_q.mode & ~st_q.c_s[CS_PIN] & ~st_q.c_s[RD_PIN];
      wr_start = wr_now & ~st_q.wr_act;
      rd_start = rd_now & ~st_q.rd_act;
      wr_end = st_q.wr_act & ~wr_now;
      rd_end = st_q.rd_act & ~rd_now;
      wr_fire = st_q.wr_pend & st_q.wr_arm & (st_q.ph == PHASE_FOUR);
      rd_fire = st_q.rd_pend & st_q.rd_arm & (st_q.ph == PHASE_FOUR);
      rbyte = '0;

      st_d.c_m = ctrl_i;
      st_d.c_s = st_q.c_m;
      st_d.d_m = data_i;
      st_d.d_s = st_q.d_m;
      st_d.ph = st_q.ph + PH_STEP;
      st_d.wr_act = wr_now;
      st_d.rd_act = rd_now;

      // Keep sampling while selected; the last sample before release stays
      if (wr_now)
      begin
         st_d.in_lat = st_q.d_s;
      end

      // Completion waits for the next phase two, then fires on phase four
      if (wr_end)
      begin
         st_d.wr_pend = 1'b1;
         st_d.wr_arm = 1'b0;
      end
      else if (wr_fire)
      begin
         st_d.wr_pend = 1'b0;
         st_d.wr_arm = 1'b0;
      end
      else if (st_q.wr_pend && st_q.ph == PHASE_TWO)
      begin
         st_d.wr_arm = 1'b1;
      end
      if (rd_end)
      begin
         st_d.rd_pend = 1'b1;
         st_d.rd_arm = 1'b0;
      end
      else if (rd_fire)
      begin
         st_d.rd_pend = 1'b0;
         st_d.rd_arm = 1'b0;
      end
      else if (st_q.rd_pend && st_q.ph == PHASE_TWO)
      begin
         st_d.rd_arm = 1'b1;
      end

      // Register reads; unmapped indices read zero and still acknowledge
      if (hit(idx, IDX_DATA))
      begin
         // Slave mode returns the input latch, port mode the pins on input bits and the output latch on output bits
         rbyte = st_q.mode ? st_q.in_lat
               : (st_q.d_s & st_q.ddir) | (st_q.out_lat & ~st_q.ddir);
      end
      else if (hit(idx, IDX_CPORT))
      begin
         rbyte[DIR_MSB:0] = (st_q.c_s & st_q.cdir) | (st_q.cport & ~st_q.cdir);
      end
      else if (hit(idx, IDX_FLAGS))
      begin
         rbyte = st_q.flags;
      end
      else if (hit(idx, IDX_DDIR))
      begin
         rbyte = st_q.ddir;
      end
      else if (hit(idx, IDX_CTRL))
      begin
         rbyte[IN_FULL_BIT] = st_q.in_full;
         rbyte[OUT_FULL_BIT] = st_q.out_full;
         rbyte[OVF_BIT] = st_q.in_ovf;
         rbyte[MODE_BIT] = st_q.mode;
         rbyte[DIR_MSB:0] = st_q.cdir;
      end
      else if (hit(idx, IDX_EN))
      begin
         rbyte = st_q.en;
      end
      else if (hit(idx, IDX_ANA))
      begin
         rbyte = st_q.ana;
      end

      st_d.ack = req;
      st_d.rdat = '0;
      if (req && !wb_we_i)
      begin
         st_d.rdat = 32'(rbyte);
         if (hit(idx, IDX_DATA))
         begin
            st_d.in_full = 1'b0;
         end
         // Reading the flags hands the event over to software
         if (hit(idx, IDX_FLAGS))
         begin
            st_d.flags[PIF_BIT] = 1'b0;
         end
      end

      if (req && wb_we_i && wb_sel_i[0])
      begin
         if (hit(idx, IDX_DATA))
         begin
            st_d.out_lat = wb_dat_i[7:0];
            st_d.out_full = st_q.mode;
         end
         else if (hit(idx, IDX_CPORT))
         begin
            st_d.cport = wb_dat_i[DIR_MSB:0];
         end
         else if (hit(idx, IDX_FLAGS))
         begin
            st_d.flags = wb_dat_i[7:0];
         end
         else if (hit(idx, IDX_DDIR))
         begin
            st_d.ddir = wb_dat_i[7:0];
         end
         else if (hit(idx, IDX_CTRL))
         begin
            st_d.in_ovf = wb_dat_i[OVF_BIT];
            st_d.mode = wb_dat_i[MODE_BIT];
            st_d.cdir = wb_dat_i[DIR_MSB:0];
         end
         else if (hit(idx, IDX_EN))
         begin
            st_d.en = wb_dat_i[7:0];
         end
         else if (hit(idx, IDX_ANA))
         begin
            st_d.ana = wb_dat_i[7:0];
         end
      end

      // Hardware events come after software so they win over a software set or clear; only the slave mode check comes after them and clears both full flags
      if (rd_start)
      begin
         st_d.out_full = 1'b0;
      end
      if (wr_start && st_q.in_full)
      begin
         st_d.in_ovf = 1'b1;
      end
      if (wr_fire)
      begin
         st_d.in_full = 1'b1;
         st_d.flags[PIF_BIT] = 1'b1;
      end
      if (rd_fire)
      begin
         st_d.flags[PIF_BIT] = 1'b1;
      end
      if (!st_d.mode)
      begin
         st_d.in_full = 1'b0;
         st_d.out_full = 1'b0;
      end

      // Pin drivers; the direction register has no say in slave mode
      st_d.dout = st_d.out_lat;
      st_d.doe = st_d.mode ? {8{st_d.rd_act}} : ~st_d.ddir;
      st_d.coe = ~st_d.cdir;
      st_d.irq = |(st_d.flags & st_d.en);

      if (rst_i)
      begin
         st_d = '0;
         st_d.ddir = DDIR_RST;
         st_d.doe = ~DDIR_RST;
         st_d.cdir = CTRL_RST[DIR_MSB:0];
         st_d.coe = ~CTRL_RST[DIR_MSB:0];
         st_d.flags = FLAGS_RST;
         st_d.en = EN_RST;
         st_d.ana = ANA_RST;
         st_d.mode = CTRL_RST[MODE_BIT];
      end
   end

   always_ff @(posedge clk_i)
   begin
      st_q <= st_d;
   end

   assign wb_dat_o = st_q.rdat;
   assign wb_ack_o = st_q.ack;
   assign data_o = st_q.dout;
   assign data_oe_o = st_q.doe;
   assign ctrl_o = st_q.cport;
   assign ctrl_oe_o = st_q.coe;
   assign irq_o = st_q.irq;

   property p_wr_done;
      @(posedge clk_i) disable iff (rst_i)
      wr_fire |=> st_q.in_full && st_q.flags[PIF_BIT];
   endproperty
   a_wr_done: assert property (p_wr_done)
      else $error("write completion did not set full and irq flags");

   property p_wr_delay;
      @(posedge clk_i) disable iff (rst_i)
      wr_end && !st_q.wr_pend |-> ##[3:6] wr_fire;
   endproperty
   a_wr_delay: assert property (p_wr_delay)
      else $error("write completion not within phase window");

   property p_ovf;
      @(posedge clk_i) disable iff (rst_i)
      wr_start && st_q.in_full |=> st_q.in_ovf;
   endproperty
   a_ovf: assert property (p_ovf)
      else $error("overflow not flagged on write to full latch");

   property p_obf_clr;
      @(posedge clk_i) disable iff (rst_i)
      rd_start |=> !st_q.out_full;
   endproperty
   a_obf_clr: assert property (p_obf_clr)
      else $error("output full not cleared at host read");

   property p_drive;
      @(posedge clk_i) disable iff (rst_i)
      st_q.mode && st_q.rd_act |-> data_oe_o == 8'hff
         && data_o == st_q.out_lat;
   endproperty
   a_drive: assert property (p_drive)
      else $error("output latch not driven during host read");

   property p_rd_irq;
      @(posedge clk_i) disable iff (rst_i)
      rd_fire |=> st_q.flags[PIF_BIT];
   endproperty
   a_rd_irq: assert property (p_rd_irq)
      else $error("read completion did not set irq flag");

   property p_off;
      @(posedge clk_i) disable iff (rst_i)
      !st_q.mode |-> !st_q.in_full && !st_q.out_full;
   endproperty
   a_off: assert property (p_off)
      else $error("full flags set outside slave mode");

   property p_unsel;
      @(posedge clk_i) disable iff (rst_i)
      st_q.c_s[CS_PIN] |-> !wr_start && !rd_start ##1 st_q.doe == 8'h00
         || !st_q.mode;
   endproperty
   a_unsel: assert property (p_unsel)
      else $error("activity while chip select high");

   property p_obf_set;
      @(posedge clk_i) disable iff (rst_i)
      req && wb_we_i && wb_sel_i[0] && hit(idx, IDX_DATA) && st_q.mode
         && !rd_start |=> st_q.out_full;
   endproperty
   a_obf_set: assert property (p_obf_set)
      else $error("firmware write did not set output full");

   property p_irq;
      @(posedge clk_i) disable iff (rst_i)
      irq_o == |(st_q.flags & st_q.en);
   endproperty
   a_irq: assert property (p_irq)
      else $error("interrupt output disagrees with flags and enables");

endmodule

// File: tb/host_model.sv
// External processor model driving the byte port strobes and data bus
`timescale 1ns/1ns
module host_model
(
   // Clock
   input wire logic clk_i,
   // Shared bus
   input wire logic [7:0] pins_i,
   input wire logic [7:0] oe_i,
   output logic [7:0] data_o,
   output logic [2:0] ctrl_o
);
   logic busy = 1'b0;
   logic [7:0] wd = 8'h00;
   logic [7:0] idle = 8'h5a;
   logic [2:0] ctl = 3'h7;
   assign data_o = busy ? wd : idle;
   assign ctrl_o = ctl;
   // A released bus toggles so a stale byte never passes for data
   always @(posedge clk_i)
      idle <= ~idle;
   // Strobes low 6 cycles, data kept 3 cycles past release, then idle
   task xfer(input logic cs_n, input logic wr, input logic [7:0] d,
             output logic [7:0] q, output logic [7:0] oe);
      begin
         busy <= wr;
         wd <= d;
         ctl <= {cs_n, ~wr, wr};
         repeat (6) @(posedge clk_i);
         q = pins_i;
         oe = oe_i;
         ctl <= 3'h7;
         repeat (3) @(posedge clk_i);
         busy <= 1'b0;
         repeat (10) @(posedge clk_i);
      end
   endtask
endmodule

// File: tb/host_byte_port_test.sv
// Self-checking bench for the host byte port
`timescale 1ns/1ns
module host_byte_port_test import host_port_pkg::*;;
   localparam logic [9:0] A_DATA = {IDX_DATA, 2'b00};
   localparam logic [9:0] A_CPORT = {IDX_CPORT, 2'b00};
   localparam logic [9:0] A_DDIR = {IDX_DDIR, 2'b00};
   localparam logic [9:0] A_FLAGS = {IDX_FLAGS, 2'b00};
   localparam logic [9:0] A_CTRL = {IDX_CTRL, 2'b00};
   localparam logic [9:0] A_EN = {IDX_EN, 2'b00};
   localparam logic [9:0] A_ANA = {IDX_ANA, 2'b00};
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [9:0] adr = 10'h000;
   logic [31:0] wdat = 32'h0;
   logic [3:0] sel = 4'hf;
   logic [31:0] rdat;
   logic ack, irq;
   logic [7:0] dout, doe, hdat, pins, q, b, hq, oe;
   logic [2:0] hctl, cout, coe;
   int error_cnt = 0;
   int checks_done = 0;
   int unsigned s;
   always #2 clk_i = ~clk_i;
   assign pins = (doe === 8'hff) ? dout : hdat;
   host_byte_port i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
      .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .data_i(pins),
      .data_o(dout), .data_oe_o(doe), .ctrl_i(hctl), .ctrl_o(cout),
      .ctrl_oe_o(coe), .irq_o(irq));
   host_model i_host (.clk_i(clk_i), .pins_i(pins), .oe_i(doe),
      .data_o(hdat), .ctrl_o(hctl));
   function logic [7:0] cx(logic ib, logic ob, logic ov, logic md);
      return {ib, ob, ov, md, 4'h7};
   endfunction
   task wb(input logic w, input logic [9:0] a, input logic [7:0] d);
      begin
         cyc <= 1'b1;
         stb <= 1'b1;
         we <= w;
         adr <= a;
         wdat <= {24'h0, d};
         do @(posedge clk_i); while (ack !== 1'b1);
         q = rdat[7:0];
         cyc <= 1'b0;
         stb <= 1'b0;
         @(posedge clk_i);
      end
   endtask
   task chk(input logic [7:0] g, input logic [7:0] e);
      begin
         checks_done++;
         if (g !== e)
         begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
         end
      end
   endtask
   task rd(input logic [9:0] a, input logic [7:0] e);
      begin
         wb(1'b0, a, 8'h00);
         chk(q, e);
      end
   endtask
   task print_verdict;
      begin
         $display("Errors %0d, checks %0d", error_cnt, checks_done);
         if (error_cnt == 0 && checks_done > 0)
            $display("Run complete: PASS");
         else
            $display("Run complete: FAIL");
         $finish;
      end
   endtask
   initial
   begin
      #40000;
      error_cnt++;
      print_verdict;
   end
   initial
   begin
      s = $urandom(5928);
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      rd(A_CTRL, CTRL_RST);
      rd(A_FLAGS, FLAGS_RST);
      rd(A_EN, EN_RST);
      rd(A_ANA, ANA_RST);
      rd(10'h3fc, 8'h00);
      b = 8'($urandom);
      wb(1'b1, A_ANA, b);
      rd(A_ANA, b);
      b = 8'($urandom);
      wb(1'b1, A_CPORT, b);
      chk({5'h0, cout}, {5'h0, b[2:0]});
      // Port mode follows the direction register; slave mode must not
      wb(1'b1, A_DDIR, 8'h0f);
      chk(doe, 8'hf0);
      wb(1'b1, A_CTRL, 8'h00);
      chk({5'h0, coe}, 8'h07);
      wb(1'b1, A_CTRL, 8'h07);
      i_host.xfer(1'b0, 1'b1, 8'h3c, hq, oe);
      rd(A_CTRL, CTRL_RST);
      wb(1'b1, A_CTRL, 8'hff);
      rd(A_CTRL, cx(0, 0, 1, 1));
      wb(1'b1, A_CTRL, 8'h1f);
      rd(A_CTRL, cx(0, 0, 0, 1));
      chk({5'h0, coe}, 8'h00);
      b = 8'($urandom);
      i_host.xfer(1'b0, 1'b1, b, hq, oe);
      chk(oe, 8'h00);
      rd(A_CTRL, cx(1, 0, 0, 1));
      chk({7'h0, irq}, 8'h00);
      wb(1'b1, A_EN, 8'h80);
      chk({7'h0, irq}, 8'h01);
      rd(A_FLAGS, 8'h80);
      chk({7'h0, irq}, 8'h00);
      rd(A_FLAGS, 8'h00);
      rd(A_DATA, b);
      rd(A_CTRL, cx(0, 0, 0, 1));
      i_host.xfer(1'b0, 1'b1, 8'ha5, hq, oe);
      i_host.xfer(1'b0, 1'b1, 8'h5a, hq, oe);
      rd(A_CTRL, cx(1, 0, 1, 1));
      chk({7'h0, irq}, 8'h01);
      wb(1'b1, A_FLAGS, 8'h00);
      chk({7'h0, irq}, 8'h00);
      rd(A_DATA, 8'h5a);
      rd(A_CTRL, cx(0, 0, 1, 1));
      wb(1'b1, A_CTRL, 8'h17);
      i_host.xfer(1'b1, 1'b1, 8'h99, hq, oe);
      rd(A_CTRL, cx(0, 0, 0, 1));
      rd(A_DATA, 8'h5a);
      rd(A_FLAGS, 8'h00);
      wb(1'b1, A_DATA, 8'h42);
      i_host.xfer(1'b1, 1'b0, 8'h00, hq, oe);
      chk(oe, 8'h00);
      rd(A_CTRL, cx(0, 1, 0, 1));
      wb(1'b1, A_FLAGS, 8'h00);
      repeat (4)
      begin
         b = 8'($urandom);
         wb(1'b1, A_DATA, b);
         i_host.xfer(1'b0, 1'b0, 8'h00, hq, oe);
         chk(hq, b);
         chk(oe, 8'hff);
         rd(A_CTRL, cx(0, 0, 0, 1));
         rd(A_FLAGS, 8'h80);
         wb(1'b1, A_FLAGS, 8'h00);
         b = 8'($urandom);
         i_host.xfer(1'b0, 1'b1, b, hq, oe);
         rd(A_DATA, b);
         // Clearing here keeps the next read completion check honest
         rd(A_FLAGS, 8'h80);
      end
      i_host.xfer(1'b0, 1'b1, 8'h11, hq, oe);
      i_host.xfer(1'b0, 1'b1, 8'h22, hq, oe);
      wb(1'b1, A_DATA, 8'h33);
      rd(A_CTRL, cx(1, 1, 1, 1));
      wb(1'b1, A_CTRL, 8'h27);
      rd(A_CTRL, cx(0, 0, 1, 0));
      print_verdict;
   end
endmodule
